// ===== drb_params.svh
// constants of the read-burst path: offsets, fields, reset values, counts
//
// Overview of operation
// - timing holds only with DLL on, locked
// - fixed 8, fixed chop, on-the-fly via A12
// - plain read leaves the bank open
// - auto precharge read closes bank after burst
// - eight beats for mode 00, or 01+A12
`ifndef DRB_PARAMS_SVH
`define DRB_PARAMS_SVH

// register byte offsets
`define DRB_OFS_CTRL       8'h00
`define DRB_OFS_STAT       8'h04
`define DRB_OFS_BANK       8'h08

// control register fields
`define DRB_CTRL_BM_LSB    0
`define DRB_CTRL_DLL_BIT   2
`define DRB_CTRL_CL_LSB    3
`define DRB_CTRL_AL_LSB    8

// status register fields
`define DRB_STAT_LOCK_BIT  0
`define DRB_STAT_BUSY_BIT  1
`define DRB_STAT_DROP_BIT  2
`define DRB_STAT_UNDR_BIT  3

// reset values of the control fields
`define DRB_RST_BMODE      2'h0
`define DRB_RST_DLL_EN     1'h1
`define DRB_RST_CL         5'h0B
`define DRB_RST_AL         5'h00

// command address bits and burst sizes
`define DRB_A10            10
`define DRB_A12            12
`define DRB_BEATS_BL8      4'h8
`define DRB_BEATS_BC4      4'h4

// CK rising edges from enable to lock
`define DRB_DLL_LOCK_CK    16

`endif

// ===== drb_pkg.sv
// types shared by the read-burst path
package drb_pkg;

    // path states, gray along idle-wait-burst-close
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_BURST = 2'b11,
        ST_CLOSE = 2'b10
    } drb_state_type;

    // burst length selection of the mode register
    typedef enum logic [1:0] {
        BM_FIXED8 = 2'b00,
        BM_OTF    = 2'b01,
        BM_FIXED4 = 2'b10,
        BM_RSVD   = 2'b11
    } drb_bmode_type;

    // decoded command kinds
    typedef enum logic [1:0] {
        K_NOP  = 2'b00,
        K_ACT  = 2'b01,
        K_READ = 2'b11,
        K_PRE  = 2'b10
    } drb_kind_type;

    // command and address bus as seen at the pins
    typedef struct packed {
        logic        cs_n;
        logic        act_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [13:0] addr;
        logic [1:0]  bg;
        logic [1:0]  ba;
    } drb_cmd_type;

endpackage

// ===== drb_sync.sv
// two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module drb_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule

// ===== drb_fifo.sv
// small buffer with valid/ready on both sides and registered flags
`timescale 1ns/1ps
module drb_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic      [W-1:0] out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_ff [DEPTH];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic          push;
    logic          pop;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem_ff[rp_ff];

    // occupancy; flags are flops so the ready never ripples back
    always_comb begin
        nxt_cnt = cnt_ff;
        if (push && !pop) nxt_cnt = cnt_ff + CW'(1);
        if (pop && !push) nxt_cnt = cnt_ff - CW'(1);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff    <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            cnt_ff    <= nxt_cnt;
            in_ready  <= (nxt_cnt != CW'(DEPTH));
            out_valid <= (nxt_cnt != '0);
        end
    end

    // pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else begin
            if (push) wp_ff <= (wp_ff == AW'(DEPTH - 1)) ? '0 : wp_ff + AW'(1);
            if (pop)  rp_ff <= (rp_ff == AW'(DEPTH - 1)) ? '0 : rp_ff + AW'(1);
        end
    end

    // storage carries no reset
    always_ff @(posedge clk) begin
        if (push) mem_ff[wp_ff] <= in_data;
    end
endmodule

// ===== drb_top.sv
// read-burst path: command sampling, latency, burst out, registers
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "drb_params.svh"
module drb_top #(
    parameter int DQ_W        = 8,
    parameter int DLL_LOCK_CK = `DRB_DLL_LOCK_CK
) (
    input  wire logic                CLOCK,
    input  wire logic                RESETN,
    input  wire logic                CK,
    input  wire drb_pkg::drb_cmd_type CMD,
    input  wire logic [7:0]          REG_ADDR,
    input  wire logic [31:0]         REG_WDATA,
    input  wire logic                REG_WR,
    input  wire logic                REG_RD,
    output logic      [31:0]         REG_RDATA,
    input  wire logic [DQ_W-1:0]     RD_DATA,
    input  wire logic                RD_VALID,
    output logic                     RD_READY,
    input  wire logic [DQ_W-1:0]     DQ_IN,
    output logic      [DQ_W-1:0]     DQ_OUT,
    output logic                     DQ_OE,
    input  wire logic                DQS_IN,
    output logic                     DQS_OUT,
    output logic                     DQS_OE
);
    import drb_pkg::*;

    localparam int CW = $bits(drb_cmd_type);

    // command decode, shared by the path and its checks
    function automatic drb_kind_type cmd_kind(input drb_cmd_type c);
        cmd_kind = K_NOP;
        if (!c.cs_n) begin
            if (!c.act_n)
                cmd_kind = K_ACT;
            else if ({c.ras_n, c.cas_n, c.we_n} == 3'b101)
                cmd_kind = K_READ;
            else if ({c.ras_n, c.cas_n, c.we_n} == 3'b010)
                cmd_kind = K_PRE;
        end
    endfunction

    // eight beats for fixed 8 or on-the-fly with A12 high
    function automatic logic burst_is8(input logic [1:0] m,
                                       input logic a12);
        burst_is8 = (m == BM_FIXED8) || ((m == BM_OTF) && a12);
    endfunction

    logic [CW:0]      sync_q;
    logic             ck_s;
    drb_cmd_type      cmd_s;
    logic             ck_d_ff;
    logic             ck_rise;
    logic             ck_fall;
    drb_kind_type     kind;
    logic [1:0]       bmode_ff;
    logic             dll_en_ff;
    logic [4:0]       cl_ff;
    logic [4:0]       al_ff;
    logic [15:0]      dll_cnt_ff;
    logic             dll_locked_ff;
    drb_state_type    st_ff;
    logic [5:0]       rl;
    logic [5:0]       rl_eff;
    logic [5:0]       lat_ff;
    logic [3:0]       left_ff;
    logic [3:0]       beats_ff;
    logic [3:0]       bank_ff;
    logic             ap_ff;
    logic [15:0]      bank_open_ff;
    logic             dropped_ff;
    logic             underrun_ff;
    logic             rd_hit;
    logic             accept;
    logic             pre_hit;
    logic             first_edge;
    logic             next_edge;
    logic             beat_edge;
    logic             end_edge;
    logic             abort;
    logic [DQ_W-1:0]  fifo_data;
    logic             fifo_valid;
    logic             fifo_pop;
    logic [31:0]      rd_word;
    logic [31:0]      stat_word;
    logic             wr_stat;

    // CK and the command bus cross together so they stay aligned
    drb_sync #(.W(CW + 1)) u_sync (
        .clk   (CLOCK),
        .rst_n (RESETN),
        .d     ({CMD, CK}),
        .q     (sync_q)
    );

    // the stall of the core reaches the data source through RD_READY
    drb_fifo #(.W(DQ_W), .DEPTH(2)) u_fifo (
        .clk       (CLOCK),
        .rst_n     (RESETN),
        .in_data   (RD_DATA),
        .in_valid  (RD_VALID),
        .in_ready  (RD_READY),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    assign ck_s    = sync_q[0];
    assign cmd_s   = sync_q[CW:1];
    assign ck_rise = ck_s && !ck_d_ff;
    assign ck_fall = !ck_s && ck_d_ff;
    assign kind    = cmd_kind(cmd_s);

    // edge detector on the synchronised CK
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) ck_d_ff <= 1'b0;
        else         ck_d_ff <= ck_s;
    end

    // read latency: additive plus CAS, at least one CK
    assign rl     = {1'b0, al_ff} + {1'b0, cl_ff};
    assign rl_eff = (rl == 6'h00) ? 6'h01 : rl;

    // a read is taken only idle and locked; others are dropped
    assign rd_hit     = ck_rise && (kind == K_READ);
    assign accept     = rd_hit && (st_ff == ST_IDLE) && dll_locked_ff;
    assign pre_hit    = ck_rise && (kind == K_PRE);
    assign first_edge = (st_ff == ST_WAIT) && ck_rise && (lat_ff == 6'h01);
    assign next_edge  = (st_ff == ST_BURST) && (ck_rise || ck_fall)
                        && (left_ff != 4'h0);
    assign end_edge   = (st_ff == ST_BURST) && ck_rise && (left_ff == 4'h0);
    // a falling enable aborts at once, so the pins drop with the lock
    assign abort      = (!dll_locked_ff || !dll_en_ff)
                        && ((st_ff == ST_WAIT) || (st_ff == ST_BURST));
    assign beat_edge  = (first_edge || next_edge) && !abort;
    assign fifo_pop   = beat_edge && fifo_valid;

    // lock after a count of CK rises; dropping enable loses lock
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            dll_cnt_ff    <= 16'h0000;
            dll_locked_ff <= 1'b0;
        end else if (!dll_en_ff) begin
            dll_cnt_ff    <= 16'h0000;
            dll_locked_ff <= 1'b0;
        end else if (ck_rise && !dll_locked_ff) begin
            dll_cnt_ff    <= dll_cnt_ff + 16'h0001;
            dll_locked_ff <= (dll_cnt_ff + 16'h0001 == 16'(DLL_LOCK_CK));
        end
    end

    // path state
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            st_ff <= ST_IDLE;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    if (accept) st_ff <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (abort)           st_ff <= ST_IDLE;
                    else if (first_edge) st_ff <= ST_BURST;
                end
                ST_BURST: begin
                    if (abort)
                        st_ff <= ST_IDLE;
                    else if (end_edge)
                        st_ff <= ap_ff ? ST_CLOSE : ST_IDLE;
                end
                ST_CLOSE: st_ff <= ST_IDLE;
                default:  st_ff <= ST_IDLE;
            endcase
        end
    end

    // burst parameters caught with the read command
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            beats_ff <= `DRB_BEATS_BL8;
            bank_ff  <= 4'h0;
            ap_ff    <= 1'b0;
        end else if (accept) begin
            beats_ff <= burst_is8(bmode_ff, cmd_s.addr[`DRB_A12])
                        ? `DRB_BEATS_BL8 : `DRB_BEATS_BC4;
            bank_ff  <= {cmd_s.bg, cmd_s.ba};
            ap_ff    <= cmd_s.addr[`DRB_A10];
        end
    end

    // latency and beat counters
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            lat_ff  <= 6'h00;
            left_ff <= 4'h0;
        end else begin
            if (accept)
                lat_ff <= rl_eff;
            else if ((st_ff == ST_WAIT) && ck_rise)
                lat_ff <= lat_ff - 6'h01;
            if (first_edge)
                left_ff <= beats_ff - 4'h1;
            else if (next_edge)
                left_ff <= left_ff - 4'h1;
        end
    end

    // pins: a beat and a strobe level per CK edge, released at the end
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            DQ_OUT  <= '0;
            DQ_OE   <= 1'b0;
            DQS_OUT <= 1'b0;
            DQS_OE  <= 1'b0;
        end else if (beat_edge) begin
            DQ_OUT  <= fifo_valid ? fifo_data : '0;
            DQ_OE   <= 1'b1;
            DQS_OUT <= ck_s;
            DQS_OE  <= 1'b1;
        end else if (end_edge || abort) begin
            DQ_OUT  <= '0;
            DQ_OE   <= 1'b0;
            DQS_OUT <= 1'b0;
            DQS_OE  <= 1'b0;
        end
    end

    // open banks: activate sets, precharge or auto precharge clears
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            bank_open_ff <= 16'h0000;
        end else begin
            if (st_ff == ST_CLOSE)
                bank_open_ff[bank_ff] <= 1'b0;
            if (pre_hit && cmd_s.addr[`DRB_A10])
                bank_open_ff <= 16'h0000;
            else if (pre_hit)
                bank_open_ff[{cmd_s.bg, cmd_s.ba}] <= 1'b0;
            if (ck_rise && (kind == K_ACT))
                bank_open_ff[{cmd_s.bg, cmd_s.ba}] <= 1'b1;
        end
    end

    assign wr_stat = REG_WR && (REG_ADDR == `DRB_OFS_STAT);

    // sticky flags clear on a written one; a new event wins the clear
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            dropped_ff  <= 1'b0;
            underrun_ff <= 1'b0;
        end else begin
            if (rd_hit && !accept)
                dropped_ff <= 1'b1;
            else if (wr_stat && REG_WDATA[`DRB_STAT_DROP_BIT])
                dropped_ff <= 1'b0;
            if (beat_edge && !fifo_valid)
                underrun_ff <= 1'b1;
            else if (wr_stat && REG_WDATA[`DRB_STAT_UNDR_BIT])
                underrun_ff <= 1'b0;
        end
    end

    // control register; mode changes take effect at the next read
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            bmode_ff  <= `DRB_RST_BMODE;
            dll_en_ff <= `DRB_RST_DLL_EN;
            cl_ff     <= `DRB_RST_CL;
            al_ff     <= `DRB_RST_AL;
        end else if (REG_WR && (REG_ADDR == `DRB_OFS_CTRL)) begin
            bmode_ff  <= REG_WDATA[`DRB_CTRL_BM_LSB +: 2];
            dll_en_ff <= REG_WDATA[`DRB_CTRL_DLL_BIT];
            cl_ff     <= REG_WDATA[`DRB_CTRL_CL_LSB +: 5];
            al_ff     <= REG_WDATA[`DRB_CTRL_AL_LSB +: 5];
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`DRB_STAT_LOCK_BIT] = dll_locked_ff;
        stat_word[`DRB_STAT_BUSY_BIT] = (st_ff != ST_IDLE);
        stat_word[`DRB_STAT_DROP_BIT] = dropped_ff;
        stat_word[`DRB_STAT_UNDR_BIT] = underrun_ff;
        case (REG_ADDR)
            `DRB_OFS_CTRL: rd_word = {19'h0_0000, al_ff, cl_ff,
                                      dll_en_ff, bmode_ff};
            `DRB_OFS_STAT: rd_word = stat_word;
            `DRB_OFS_BANK: rd_word = {16'h0000, bank_open_ff};
            default:       rd_word = 32'h0000_0000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN)     REG_RDATA <= 32'h0000_0000;
        else if (REG_RD) REG_RDATA <= rd_word;
        else             REG_RDATA <= 32'h0000_0000;
    end

    // helper counters that only the checks read
    logic [6:0] rise_chk_ff;
    logic [5:0] rl_chk_ff;
    logic [3:0] seen_chk_ff;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rise_chk_ff <= 7'h00;
            rl_chk_ff   <= 6'h00;
            seen_chk_ff <= 4'h0;
        end else if (accept) begin
            rise_chk_ff <= 7'h00;
            rl_chk_ff   <= rl_eff;
            seen_chk_ff <= 4'h0;
        end else begin
            if ((st_ff == ST_WAIT) && ck_rise)
                rise_chk_ff <= rise_chk_ff + 7'h01;
            if (beat_edge)
                seen_chk_ff <= seen_chk_ff + 4'h1;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    sequence s_burst_to_close;
        (st_ff == ST_BURST) ##1 (st_ff == ST_CLOSE);
    endsequence

    sequence s_plain_end;
        (st_ff == ST_BURST && !ap_ff && !abort) ##1 (st_ff == ST_IDLE);
    endsequence

    chk_oe_needs_lock: assert property (
        DQ_OE |-> dll_locked_ff)
        else $error("data driven while the DLL is not locked");

    chk_drop_unlocked: assert property (
        (rd_hit && !dll_locked_ff) |=> dropped_ff && (st_ff == ST_IDLE))
        else $error("read taken while the DLL is not locked");

    chk_fixed8_len: assert property (
        (accept && bmode_ff == BM_FIXED8) |=> beats_ff == `DRB_BEATS_BL8)
        else $error("fixed mode did not give eight beats");

    chk_otf_select: assert property (
        (accept && bmode_ff == BM_OTF) |=>
        beats_ff == ($past(cmd_s.addr[`DRB_A12]) ? 4'h8 : 4'h4))
        else $error("on-the-fly burst length not taken from A12");

    chk_latency_count: assert property (
        first_edge |-> (rise_chk_ff + 7'h01 == {1'b0, rl_chk_ff}))
        else $error("first beat not at the read latency");

    chk_burst_beats: assert property (
        end_edge |-> (seen_chk_ff == beats_ff) ##1 !DQ_OE && !DQS_OE)
        else $error("burst beat count wrong");

    chk_strobe_follow: assert property (
        beat_edge |=> DQS_OE && (DQS_OUT == $past(ck_s)))
        else $error("strobe edge not matched to beat");

    chk_auto_close: assert property (
        s_burst_to_close |=> !bank_open_ff[bank_ff] && st_ff == ST_IDLE)
        else $error("auto precharge did not close the bank");

    chk_plain_open: assert property (
        s_plain_end |-> (bank_open_ff[bank_ff] ==
                         $past(bank_open_ff[bank_ff], 2)) || $past(pre_hit))
        else $error("plain read changed the bank state");
endmodule

// ===== drb_ctrl_model.sv
// controller model: free-running memory clock and command issue
`timescale 1ns/1ps
module drb_ctrl_model #(
    parameter real HALF_NS = 62.5
) (
    output logic                 ck,
    output drb_pkg::drb_cmd_type cmd
);
    import drb_pkg::*;

    // memory clock runs free, the dll counts its rises to gain lock
    initial begin
        ck = 1'b0;
        forever #(HALF_NS) ck = ~ck;
    end

    // deselected at start
    initial cmd = '1;

    // one command set up at a fall and held a full period round the rise;
    // reads are only issued once the previous burst is over, so any
    // turnaround gap stays far above its minimum
    task automatic issue(
        input logic [3:0]  op,
        input logic [13:0] addr,
        input logic [1:0]  bg,
        input logic [1:0]  ba
    );
        @(negedge ck);
        cmd <= {1'b0, op, addr, bg, ba};
        @(negedge ck);
        // deselect with inverted fields so stale values never look valid
        cmd <= {1'b1, ~op, ~addr, ~bg, ~ba};
    endtask
endmodule

// ===== drb_top_tb_top.sv
// self-checking bench of the read-burst path
`timescale 1ns/1ps
module drb_top_tb_top;
    import drb_pkg::*;

    logic        clock;
    logic        resetn;
    logic        ck;
    drb_cmd_type cmd;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        rd_ready;
    logic [7:0]  dq_out;
    logic        dq_oe;
    logic        dqs_out;
    logic        dqs_oe;
    logic [7:0]  feed_word;
    logic [7:0]  beats[$];
    logic        oe_d;
    logic        dqs_d;
    int          err_count;
    int          tests_run;
    int          feed_left;
    int          cyc;

    drb_ctrl_model i_drb_ctrl_model (.ck(ck), .cmd(cmd));

    drb_top #(.DLL_LOCK_CK(2)) i_drb_top (
        .CLOCK(clock), .RESETN(resetn), .CK(ck), .CMD(cmd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .RD_DATA(rd_data),
        .RD_VALID(rd_valid), .RD_READY(rd_ready), .DQ_IN(8'h00),
        .DQ_OUT(dq_out), .DQ_OE(dq_oe), .DQS_IN(1'b0),
        .DQS_OUT(dqs_out), .DQS_OE(dqs_oe)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // core-side feeder: a counting word stream, junk while not valid
    always @(posedge clock) begin
        if (rd_valid && rd_ready) begin
            feed_word = feed_word + 8'h01;
            feed_left = feed_left - 1;
        end
        rd_valid <= (feed_left > 0);
        rd_data  <= (feed_left > 0) ? feed_word : ~feed_word;
    end

    // beat monitor: a beat is the first driven cycle or a strobe change
    always @(posedge clock) begin
        if (dq_oe === 1'b1 && (oe_d !== 1'b1 || dqs_out !== dqs_d))
            beats.push_back(dq_out);
        oe_d  <= dq_oe;
        dqs_d <= dqs_out;
    end

    // hang guard, far above the sum of all scenarios
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d, errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count = err_count + 1;
        end
    endtask

    task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_rd_t(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic logic [31:0] ctrl_word(int bm, int cl, int al);
        return {19'h0_0000, 5'(al), 5'(cl), 1'b1, 2'(bm)};
    endfunction

    task automatic wait_lock();
        logic [31:0] s;
        repeat (60) begin
            reg_rd_t(8'h04, s);
            if (s[0] === 1'b1) break;
        end
    endtask

    // one read: preload the buffer, time latency, collect beats
    task automatic do_read(input logic [13:0] addr, input logic [1:0] bg,
                           input logic [1:0] ba, input int n, input int rl);
        int         rises;
        logic       ck_d;
        logic [7:0] base;
        base = feed_word;
        beats.delete();
        feed_left = n;
        repeat (10) @(posedge clock);
        check_val({31'h0, rd_ready}, 32'h0000_0000); // buffer full stalls
        i_drb_ctrl_model.issue(4'b1101, addr, bg, ba);
        rises = 0;
        ck_d = ck;
        repeat (400) begin
            @(posedge clock);
            if (ck && !ck_d) rises = rises + 1;
            ck_d = ck;
            if (dq_oe === 1'b1) break;
        end
        check_val(32'(rises), 32'(rl));
        check_val({31'h0, dqs_out}, 32'h0000_0001);
        repeat (200) begin
            @(posedge clock);
            if (dq_oe === 1'b0) break;
        end
        check_val(32'(beats.size()), 32'(n));
        foreach (beats[i])
            check_val({24'h0, beats[i]}, {24'h0, base + 8'(i)});
        feed_left = 0;
    endtask

    task automatic t_regs();
        logic [31:0] s;
        reg_rd_t(8'h00, s);
        check_val(s, 32'h0000_005C);
        @(posedge clock);
        #1 check_val(reg_rdata, 32'h0000_0000); // read data stand one cycle
        reg_rd_t(8'h0C, s);
        check_val(s, 32'h0000_0000);
        wait_lock();
        reg_rd_t(8'h04, s);
        check_val(s, 32'h0000_0001);
    endtask

    // every burst mode, with a12 both ways where it matters
    task automatic t_modes();
        int bm_t[5]  = '{0, 1, 1, 2, 3};
        int cl_t[5]  = '{11, 2, 2, 3, 2};
        int al_t[5]  = '{0, 1, 1, 0, 0};
        int a12_t[5] = '{0, 1, 0, 1, 1};
        int n_t[5]   = '{8, 8, 4, 4, 4};
        for (int k = 0; k < 5; k++) begin
            reg_wr_t(8'h00, ctrl_word(bm_t[k], cl_t[k], al_t[k]));
            do_read(14'(a12_t[k]) << 12, 2'h0, 2'h0, n_t[k],
                    cl_t[k] + al_t[k]);
        end
    endtask

    task automatic t_bank();
        logic [31:0] s;
        reg_wr_t(8'h00, ctrl_word(1, 2, 1));
        i_drb_ctrl_model.issue(4'b0111, 14'h0000, 2'h2, 2'h1);
        reg_rd_t(8'h08, s);
        check_val(s, 32'h0000_0200);
        do_read(14'h1000, 2'h2, 2'h1, 8, 3);
        reg_rd_t(8'h08, s);
        check_val(s, 32'h0000_0200);
        do_read(14'h1400, 2'h2, 2'h1, 8, 3);
        reg_rd_t(8'h08, s);
        check_val(s, 32'h0000_0000);
    endtask

    // losing the dll mid-burst releases the pins within two cycles
    task automatic t_abort();
        logic [31:0] s;
        reg_wr_t(8'h00, ctrl_word(0, 2, 0));
        feed_left = 8;
        i_drb_ctrl_model.issue(4'b1101, 14'h0000, 2'h0, 2'h0);
        repeat (300) begin
            @(posedge clock);
            if (dq_oe === 1'b1) break;
        end
        check_val({31'h0, dq_oe}, 32'h0000_0001);
        reg_wr_t(8'h00, ctrl_word(0, 2, 0) & ~32'h0000_0004);
        repeat (2) @(posedge clock);
        check_val({31'h0, dq_oe}, 32'h0000_0000);
        check_val({31'h0, dqs_oe}, 32'h0000_0000);
        reg_rd_t(8'h04, s);
        check_val(s & 32'h0000_0003, 32'h0000_0000);
        feed_left = 0;
    endtask

    // with the dll off a read must not drive the pins
    task automatic t_dll();
        logic [31:0] s;
        int          hi;
        reg_wr_t(8'h00, ctrl_word(0, 2, 0) & ~32'h0000_0004);
        repeat (20) @(posedge clock);
        reg_rd_t(8'h04, s);
        check_val(s & 32'h0000_0001, 32'h0000_0000);
        i_drb_ctrl_model.issue(4'b1101, 14'h0000, 2'h0, 2'h0);
        hi = 0;
        repeat (300) begin
            @(posedge clock);
            if (dq_oe !== 1'b0) hi = hi + 1;
        end
        check_val(32'(hi), 32'h0000_0000);
        reg_rd_t(8'h04, s);
        check_val(s & 32'h0000_0005, 32'h0000_0004);
        reg_wr_t(8'h04, 32'h0000_0004);
        reg_wr_t(8'h00, ctrl_word(0, 2, 0));
        wait_lock();
        reg_rd_t(8'h04, s);
        check_val(s, 32'h0000_0001);
    endtask

    initial begin
        resetn    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        feed_word = 8'hA0;
        feed_left = 0;
        err_count = 0;
        tests_run = 0;
        cyc       = 0;
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        t_regs();
        t_modes();
        t_bank();
        t_abort();
        t_dll();
        give_verdict();
    end
endmodule
